// ---- design/sls_pkg.sv ----
// sls_pkg: constants and bus carriers for the start latch / output select
package sls_pkg;
  // ==========================================================================
  // axi4-lite carriers
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } sls_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } sls_axi_rsp_t;

  localparam logic [1:0] SLS_OKAY   = 2'h0;
  localparam logic [1:0] SLS_SLVERR = 2'h2;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] SLS_OFS_STOP   = 8'h00;
  localparam logic [7:0] SLS_OFS_INSEL  = 8'h04;
  localparam logic [7:0] SLS_OFS_OUTSEL = 8'h20;
  localparam logic [7:0] SLS_OFS_STARTF = 8'h2C;
  localparam logic [7:0] SLS_OFS_STATUS = 8'h30;

  // ==========================================================================
  // reset values
  localparam logic [15:0] SLS_STOP_RST   = 16'h270F;  // 9999
  localparam logic [15:0] SLS_STARTF_RST = 16'h0032;  // 0.50 Hz, 0.01 Hz unit
  localparam logic [2:0][15:0] SLS_OUT_RST =
    {16'h0063, 16'h0004, 16'h0000};                   // 99, 4, 0
  localparam logic [6:0][15:0] SLS_IN_RST =
    {16'h270F, 16'h270F, 16'h0005, 16'h0019, 16'h0018, 16'h003D, 16'h003C};

  // ==========================================================================
  // input function codes
  localparam logic [15:0] SLS_C_FWD  = 16'h003C;
  localparam logic [15:0] SLS_C_REV  = 16'h003D;
  localparam logic [15:0] SLS_C_INH  = 16'h0018;      // 24
  localparam logic [15:0] SLS_C_HOLD = 16'h0019;      // 25
  localparam logic [15:0] SLS_C_JOG  = 16'h0005;

  // output and stop-method codes
  localparam logic [15:0] SLS_C_NONE = 16'h270F;      // 9999
  localparam logic [15:0] SLS_C_SD   = 16'h22B8;      // 8888
  localparam logic [15:0] SLS_C_NEG  = 16'h0064;      // 100
  localparam logic [15:0] SLS_C_MAXO = 16'h00C7;      // 199
  localparam logic [15:0] SLS_CO_LO  = 16'h0064;      // coast 0..100
  localparam logic [15:0] SLS_CS_LO  = 16'h03E8;      // 1000
  localparam logic [15:0] SLS_CS_HI  = 16'h044C;      // 1100
  localparam int unsigned SLS_F_RUN   = 0;
  localparam int unsigned SLS_F_READY = 11;
  localparam int unsigned SLS_F_PLOSS = 46;
  localparam int unsigned SLS_F_FAULT = 99;
  localparam int unsigned SLS_ST_TERM = 8;
endpackage : sls_pkg

// ---- design/sls_start_out.sv ----
// sls_start_out: start-signal latch and output terminal routing
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module sls_start_out
  import sls_pkg::*;
#(
  parameter int unsigned NUM_IN = 5,
  parameter bit          SAFETY = 1'b0
)(
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // register bus
  input  wire sls_axi_req_t       s_axi_req,
  output sls_axi_rsp_t            s_axi_rsp,
  // input terminals, asynchronous
  input  wire logic [NUM_IN-1:0]  term_in,
  // drive status, same clock
  input  wire logic [15:0]        out_freq,
  input  wire logic [99:0]        status_flags,
  input  wire logic               ploss_start,
  input  wire logic               ploss_release,
  // drive commands
  output logic                    run_cmd,
  output logic                    rev_cmd,
  output logic                    coast_stop,
  output logic                    out_shutoff,
  // output terminals: two open collector, relay
  output logic [2:0]              term_out
);
  // ==========================================================================
  // parameter checks
  if (NUM_IN < 2 || NUM_IN > 7)
  begin : g_chk
    $error("NUM_IN must lie in 2..7");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [NUM_IN-1:0]        s1;
    logic [NUM_IN-1:0]        s2;
    logic                     fwd_q;
    logic                     rev_q;
    logic                     hold_q;
    logic                     latch_run;
    logic                     latch_rev;
    logic                     hs;
    logic                     run;
    logic                     rev;
    logic                     coast;
    logic                     shutoff;
    logic                     ploss;
    logic                     ready;
    logic [2:0]               term;
    logic [15:0]              stop_m;
    logic [NUM_IN-1:0][15:0]  in_sel;
    logic [2:0][15:0]         out_sel;
    logic [15:0]              start_f;
    logic                     aw_got;
    logic                     w_got;
    logic [7:0]               awaddr;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } sls_state_t;

  sls_state_t  q_r;
  sls_state_t  q_nxt;
  logic        fwd_now;
  logic        rev_now;
  logic        hold;
  logic        jog;
  logic        inh;
  logic        hold_eff;
  logic [99:0] eff;
  logic [15:0] wval;
  logic        wok;
  logic        hit;

  // ==========================================================================
  // helpers
  function automatic logic coast_rng(input logic [15:0] v);
    coast_rng = (v <= SLS_CO_LO) || (v >= SLS_CS_LO && v <= SLS_CS_HI);
  endfunction : coast_rng

  function automatic logic dir_grp(input logic [15:0] v);
    dir_grp = (v <= SLS_CO_LO) || (v == SLS_C_NONE);
  endfunction : dir_grp

  // low byte lanes merge into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge

  function automatic logic out_ok(input logic [15:0] c, input int k);
    logic [15:0] b;
    b = (c >= SLS_C_NEG) ? c - SLS_C_NEG : c;
    if (c == SLS_C_NONE)
      out_ok = 1'b1;
    else if (c > SLS_C_MAXO)
      out_ok = 1'b0;
    else
    begin
      unique case (b)
        16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0007, 16'h0008,
        16'h000B, 16'h000C, 16'h000D, 16'h000E, 16'h000F, 16'h0010,
        16'h0014, 16'h0019, 16'h001A, 16'h002E, 16'h002F, 16'h0040,
        16'h005A, 16'h005B, 16'h005F, 16'h0060, 16'h0062, 16'h0063:
          out_ok = 1'b1;
        // safety monitor codes
        // model gate
        16'h0044, 16'h0050, 16'h0051: out_ok = SAFETY;
        // current average pulses
        // relay refuses
        16'h005D: out_ok = (k != 2);
        default: out_ok = 1'b0;
      endcase
    end
  endfunction : out_ok

  function automatic logic route(input logic [15:0] c,
                                 input logic [99:0] f);
    if (c == SLS_C_NONE || c > SLS_C_MAXO)
      route = 1'b0;
    else if (c >= SLS_C_NEG)
      route = !f[7'(c - SLS_C_NEG)];
    else
      route = f[7'(c)];
  endfunction : route

  // ==========================================================================
  // next-state logic
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.s1 = term_in;
    q_nxt.s2 = q_r.s1;
    fwd_now = q_r.s2[0] && q_r.in_sel[0] == SLS_C_FWD;
    rev_now = q_r.s2[1] && q_r.in_sel[1] == SLS_C_REV;
    hold = 1'b0;
    jog  = 1'b0;
    inh  = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (q_r.s2[i] && q_r.in_sel[i] == SLS_C_HOLD)
        hold = 1'b1;
      if (q_r.s2[i] && q_r.in_sel[i] == SLS_C_JOG)
        jog = 1'b1;
      if (q_r.s2[i] && q_r.in_sel[i] == SLS_C_INH)
        inh = 1'b1;
    end
    hold_eff = hold && !jog;
    // self-hold latch; inhibit never touches it
    // inhibit keeps latch
    if (!hold_eff)
    begin
      q_nxt.latch_run = 1'b0;
      q_nxt.latch_rev = 1'b0;
    end
    else if (q_r.fwd_q && !fwd_now)
    begin
      q_nxt.latch_run = 1'b1;
      q_nxt.latch_rev = 1'b0;
    end
    else if (q_r.rev_q && !rev_now)
    begin
      q_nxt.latch_run = 1'b1;
      q_nxt.latch_rev = 1'b1;
    end
    q_nxt.fwd_q  = fwd_now;
    q_nxt.rev_q  = rev_now;
    q_nxt.hold_q = hold_eff;
    if (hold_eff)
    begin
      q_nxt.run = q_nxt.latch_run;
      q_nxt.rev = q_nxt.latch_rev;
    end
    else if (dir_grp(q_r.stop_m))
    begin
      q_nxt.run = fwd_now ^ rev_now;
      q_nxt.rev = rev_now && !fwd_now;
    end
    else
    begin
      q_nxt.run = fwd_now;
      q_nxt.rev = fwd_now && rev_now;
    end
    // a hold release forces ramp-down even in a coast setting
    if (hold_eff || q_nxt.run)
      q_nxt.hs = 1'b0;
    else if (q_r.hold_q && q_r.latch_run)
      q_nxt.hs = 1'b1;
    q_nxt.coast = coast_rng(q_r.stop_m) && !q_nxt.run && !q_nxt.hs;
    q_nxt.shutoff = inh;
    if (ploss_start)
      q_nxt.ploss = 1'b1;
    else if (ploss_release)
      q_nxt.ploss = 1'b0;
    q_nxt.ready = 1'b1;
    // flags: drive inputs with three internal overrides
    // routed
    eff = status_flags;
    eff[SLS_F_RUN] = q_r.run && !q_r.shutoff && out_freq >= q_r.start_f;
    eff[SLS_F_READY] = q_r.ready;
    eff[SLS_F_PLOSS] = q_r.ploss;
    for (int k = 0; k < 3; k++)
      q_nxt.term[k] = route(q_r.out_sel[k], eff);

    // write channel: address and data in either order
    if (s_axi_req.awvalid && !q_r.aw_got && !q_r.bvalid)
    begin
      q_nxt.aw_got = 1'b1;
      q_nxt.awaddr = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && !q_r.w_got && !q_r.bvalid)
    begin
      q_nxt.w_got = 1'b1;
      q_nxt.wdata = s_axi_req.wdata;
      q_nxt.wstrb = s_axi_req.wstrb;
    end
    wval = 16'h0000;
    wok  = 1'b0;
    hit  = 1'b0;
    if (q_r.aw_got && q_r.w_got && !q_r.bvalid)
    begin
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got  = 1'b0;
      q_nxt.bvalid = 1'b1;
      if (q_r.awaddr == SLS_OFS_STOP)
      begin
        hit  = 1'b1;
        wval = merge(q_r.stop_m, q_r.wdata, q_r.wstrb);
        wok  = coast_rng(wval) || wval == SLS_C_NONE || wval == SLS_C_SD;
        if (wok)
          q_nxt.stop_m = wval;
      end
      if (q_r.awaddr == SLS_OFS_STARTF)
      begin
        hit = 1'b1;
        wok = 1'b1;
        q_nxt.start_f = merge(q_r.start_f, q_r.wdata, q_r.wstrb);
      end
      for (int i = 0; i < NUM_IN; i++)
        if (q_r.awaddr == SLS_OFS_INSEL + 8'(4 * i))
        begin
          hit  = 1'b1;
          wval = merge(q_r.in_sel[i], q_r.wdata, q_r.wstrb);
          wok  = !((wval == SLS_C_FWD && i != 0) ||
                   (wval == SLS_C_REV && i != 1));
          if (wok)
            q_nxt.in_sel[i] = wval;
        end
      for (int k = 0; k < 3; k++)
        if (q_r.awaddr == SLS_OFS_OUTSEL + 8'(4 * k))
        begin
          hit  = 1'b1;
          wval = merge(q_r.out_sel[k], q_r.wdata, q_r.wstrb);
          wok  = out_ok(wval, k);
          if (wok)
            q_nxt.out_sel[k] = wval;
        end
      // refused values and unmapped or read-only words answer slverr
      q_nxt.bresp = (hit && wok) ? SLS_OKAY : SLS_SLVERR;
    end
    if (q_r.bvalid && s_axi_req.bready)
      q_nxt.bvalid = 1'b0;

    // read channel: one cycle to data
    if (q_r.rvalid && s_axi_req.rready)
      q_nxt.rvalid = 1'b0;
    if (s_axi_req.arvalid && !q_r.rvalid)
    begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = SLS_OKAY;
      q_nxt.rdata  = 32'h0000_0000;
      if (s_axi_req.araddr == SLS_OFS_STOP)
        q_nxt.rdata[15:0] = q_r.stop_m;
      else if (s_axi_req.araddr == SLS_OFS_STARTF)
        q_nxt.rdata[15:0] = q_r.start_f;
      else if (s_axi_req.araddr == SLS_OFS_STATUS)
      begin
        q_nxt.rdata[6:0] = {q_r.ready, q_r.ploss, q_r.shutoff, q_r.coast,
                            q_r.latch_run, q_r.rev, q_r.run};
        q_nxt.rdata[SLS_ST_TERM +: 3] = q_r.term;
      end
      else
        q_nxt.rresp = SLS_SLVERR;
      for (int i = 0; i < NUM_IN; i++)
        if (s_axi_req.araddr == SLS_OFS_INSEL + 8'(4 * i))
        begin
          q_nxt.rdata[15:0] = q_r.in_sel[i];
          q_nxt.rresp = SLS_OKAY;
        end
      for (int k = 0; k < 3; k++)
        if (s_axi_req.araddr == SLS_OFS_OUTSEL + 8'(4 * k))
        begin
          q_nxt.rdata[15:0] = q_r.out_sel[k];
          q_nxt.rresp = SLS_OKAY;
        end
    end
  end

  // ==========================================================================
  // state register, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_r <= '0;
      q_r.stop_m  <= SLS_STOP_RST;
      q_r.start_f <= SLS_STARTF_RST;
      q_r.out_sel <= SLS_OUT_RST;
      for (int i = 0; i < NUM_IN; i++)
        q_r.in_sel[i] <= SLS_IN_RST[i];
    end
    else
      q_r <= q_nxt;
  end

  // ==========================================================================
  // outputs
  assign run_cmd     = q_r.run;
  assign rev_cmd     = q_r.rev;
  assign coast_stop  = q_r.coast;
  assign out_shutoff = q_r.shutoff;
  assign term_out    = q_r.term;
  assign s_axi_rsp = '{awready: !q_r.aw_got && !q_r.bvalid,
                       wready:  !q_r.w_got && !q_r.bvalid,
                       bresp:   q_r.bresp,
                       bvalid:  q_r.bvalid,
                       arready: !q_r.rvalid,
                       rdata:   q_r.rdata,
                       rresp:   q_r.rresp,
                       rvalid:  q_r.rvalid};

  // ==========================================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence fwd_pulse_s;
    q_r.fwd_q && hold_eff ##0 !fwd_now;
  endsequence

  sequence hold_drop_s;
    q_r.hold_q && q_r.latch_run ##1 !q_r.hold_q;
  endsequence

  coast_stop_a: assert property (
    !q_r.run && !q_r.hs && $stable(q_r.stop_m) && coast_rng(q_r.stop_m)
    |-> q_r.coast) else $error("coast stop missing");
  start_slot_a: assert property (
    q_r.in_sel[1] != SLS_C_FWD && q_r.in_sel[0] != SLS_C_REV)
    else $error("start code outside its slot");
  latch_set_a: assert property (
    fwd_pulse_s |=> q_r.latch_run && !q_r.latch_rev && q_r.run)
    else $error("forward pulse not latched");
  hold_clear_a: assert property (
    hold_drop_s |-> !q_r.latch_run && !q_r.run && !q_r.coast)
    else $error("hold release did not ramp down");
  jog_mask_a: assert property (
    jog |=> !q_r.hold_q && !q_r.latch_run) else $error("hold not masked");
  inhibit_keep_a: assert property (
    q_r.latch_run && hold_eff && inh |=> q_r.latch_run && q_r.shutoff)
    else $error("inhibit lost the latch");
  direct_dir_a: assert property (
    !hold_eff && dir_grp(q_r.stop_m) && fwd_now == rev_now |=> !q_r.run)
    else $error("direct group did not stop");
  start_dir_a: assert property (
    !hold_eff && !dir_grp(q_r.stop_m) && fwd_now && rev_now
    |=> q_r.run && q_r.rev) else $error("start+dir reverse wrong");
  out_reset_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> q_r.out_sel == SLS_OUT_RST) else $error("bad output reset");
  neg_fault_a: assert property (
    q_r.out_sel[2] == SLS_C_MAXO && $stable(q_r.out_sel[2])
    |=> term_out[2] == !$past(status_flags[SLS_F_FAULT]))
    else $error("inverted fault wrong");
  relay_pulse_a: assert property (
    q_r.out_sel[2] != 16'h005D && q_r.out_sel[2] != 16'h00C1)
    else $error("relay holds pulse code");
  ploss_hold_a: assert property (
    ploss_start ##1 !ploss_release[*2] |-> q_r.ploss ##1 q_r.ploss)
    else $error("power-loss flag dropped");
endmodule : sls_start_out

// ---- test/sls_term_model.sv ----
// sls_term_model: external switch set wired to the terminal inputs
`timescale 1ns/10ps
module sls_term_model #(
  parameter int unsigned N = 5
)(
  // clock
  input  wire logic         aclk,
  // maintained switch levels and one-shot push request
  input  wire logic [N-1:0] sw,
  input  wire logic [N-1:0] pulse,
  // terminal pins
  output logic [N-1:0]      pins
);
  logic [N-1:0] push_r = '0;
  logic [2:0]   cnt_r  = 3'h0;

  // ==========================================================================
  // momentary push button
  // a push lasts several cycles so the two-flop sync always sees it
  // one on-off pulse
  always_ff @(posedge aclk)
  begin
    if (pulse != '0)
    begin
      push_r <= pulse;
      cnt_r  <= 3'h4;
    end
    else if (cnt_r != 3'h0)
      cnt_r <= cnt_r - 3'h1;
    else
      push_r <= '0;
  end

  // contacts in parallel: push or maintained switch closes the pin
  assign pins = sw | push_r;
endmodule : sls_term_model

// ---- test/sls_start_out_tb_top.sv ----
// sls_start_out_tb_top: bench for start latch and output select
`timescale 1ns/10ps
module sls_start_out_tb_top
  import sls_pkg::*;
();
  logic         aclk    = 1'b0;
  logic         aresetn = 1'b0;
  sls_axi_req_t rq      = '0;
  sls_axi_rsp_t rs;
  logic [4:0]   sw      = '0;
  logic [4:0]   pulse   = '0;
  logic [4:0]   pins;
  logic [15:0]  freq    = '0;
  logic [99:0]  flags   = '0;
  logic         pst     = 1'b0;
  logic         prl     = 1'b0;
  logic         run, rev, coast, shut;
  logic [2:0]   tout;
  int           err_total = 0;
  int           n_tests   = 0;
  int           cyc_n     = 0;

  // ==========================================================================
  // clock, design, far side
  always #2.5 aclk = ~aclk;

  sls_start_out #(.NUM_IN(5), .SAFETY(1'b0)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_req(rq), .s_axi_rsp(rs),
    .term_in(pins), .out_freq(freq), .status_flags(flags),
    .ploss_start(pst), .ploss_release(prl), .run_cmd(run),
    .rev_cmd(rev), .coast_stop(coast), .out_shutoff(shut),
    .term_out(tout));

  sls_term_model #(.N(5)) sw_model (
    .aclk(aclk), .sw(sw), .pulse(pulse), .pins(pins));

  // ==========================================================================
  // helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge aclk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      err_total = err_total + 1;
      print_verdict();
    end
  end

  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask : cy

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // axi write: aw and w offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    rq.awaddr  <= a;
    rq.awvalid <= 1'b1;
    rq.wdata   <= {16'h0000, d};
    rq.wstrb   <= 4'h3;
    rq.wvalid  <= 1'b1;
    rq.bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
      if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1 && n < 50);
    rq.bready <= 1'b0;
    chk("bvalid", 32'h1, 32'(rs.bvalid));
    chk("bresp", 32'(e), 32'(rs.bresp));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    rq.araddr  <= a;
    rq.arvalid <= 1'b1;
    rq.rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1 && n < 50);
    rq.rready <= 1'b0;
    chk("rvalid", 32'h1, 32'(rs.rvalid));
    chk("rdata", {16'h0000, e}, rs.rdata);
    chk("rresp", 32'(r), 32'(rs.rresp));
  endtask : rd

  // pins: 0 fwd, 1 rev, 2 inhibit, 3 stop-hold, 4 jog
  task automatic pin(input logic [4:0] v);
    @(posedge aclk);
    sw <= v;
    cy(5);
  endtask : pin

  task automatic push(input logic [4:0] m);
    @(posedge aclk);
    pulse <= m;
    @(posedge aclk);
    pulse <= '0;
    cy(12);
  endtask : push

  // expected {run, rev, coast, shutoff}
  task automatic cmd(input logic [3:0] e);
    chk("cmd", 32'(e), 32'({run, rev, coast, shut}));
  endtask : cmd

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [15:0] o [3] = '{16'h0000, 16'h0004, 16'h0063};
    rd(SLS_OFS_STOP, 16'h270F, SLS_OKAY);
    for (int i = 0; i < 3; i++)
      rd(SLS_OFS_OUTSEL + 8'(4 * i), o[i], SLS_OKAY);
    rd(SLS_OFS_INSEL, SLS_C_FWD, SLS_OKAY);
    rd(SLS_OFS_INSEL + 8'h04, SLS_C_REV, SLS_OKAY);
    rd(SLS_OFS_INSEL + 8'h0C, 16'h0019, SLS_OKAY);
    rd(8'h34, 16'h0000, SLS_SLVERR);
    wr(SLS_OFS_STATUS, 16'h0001, SLS_SLVERR);
    $display("done t_regs");
  endtask : t_regs

  // values that must be refused, none of them stored
  task automatic t_refuse();
    logic [7:0]  a [7] = '{8'h00, 8'h08, 8'h04, 8'h28, 8'h28, 8'h20, 8'h20};
    logic [15:0] v [7] = '{16'd500, 16'd60, 16'd61, 16'd93, 16'd193,
                           16'd80, 16'd180};
    for (int i = 0; i < 7; i++)
      wr(a[i], v[i], SLS_SLVERR);
    rd(SLS_OFS_STOP, 16'h270F, SLS_OKAY);
    rd(SLS_OFS_OUTSEL + 8'h08, 16'h0063, SLS_OKAY);
    wr(SLS_OFS_OUTSEL, 16'd93, SLS_OKAY);
    wr(SLS_OFS_OUTSEL, 16'd0, SLS_OKAY);
    $display("done t_refuse");
  endtask : t_refuse

  // every fwd/rev combination in both decode groups
  task automatic t_wire();
    logic [1:0] ex [2][4] = '{'{2'h0, 2'h2, 2'h3, 2'h0},
                              '{2'h0, 2'h2, 2'h0, 2'h3}};
    for (int g = 0; g < 2; g++)
    begin
      wr(SLS_OFS_STOP, g ? SLS_C_SD : SLS_C_NONE, SLS_OKAY);
      for (int k = 0; k < 4; k++)
      begin
        pin(5'(k));
        cmd({ex[g][k], 2'b00});
      end
    end
    pin(5'h00);
    $display("done t_wire");
  endtask : t_wire

  task automatic t_coast();
    logic [15:0] s [2] = '{16'd50, 16'd1050};
    for (int i = 0; i < 2; i++)
    begin
      wr(SLS_OFS_STOP, s[i], SLS_OKAY);
      pin(5'h01);
      cmd(4'b1000);
      pin(5'h00);
      cmd(4'b0010);
    end
    wr(SLS_OFS_STOP, SLS_C_NONE, SLS_OKAY);
    $display("done t_coast");
  endtask : t_coast

  task automatic t_hold();
    pin(5'h08);
    push(5'h01);
    cmd(4'b1000);
    push(5'h02);
    cmd(4'b1100);
    pin(5'h0C);
    cmd(4'b1101);
    pin(5'h08);
    cmd(4'b1100);
    pin(5'h00);
    cmd(4'b0000);
    pin(5'h18);
    push(5'h01);
    cmd(4'b0000);
    pin(5'h00);
    wr(SLS_OFS_INSEL + 8'h08, SLS_C_HOLD, SLS_OKAY);
    // coast setting: hold release must still ramp down
    wr(SLS_OFS_STOP, 16'd50, SLS_OKAY);
    pin(5'h04);
    push(5'h01);
    cmd(4'b1000);
    pin(5'h00);
    cmd(4'b0000);
    wr(SLS_OFS_INSEL + 8'h08, SLS_C_INH, SLS_OKAY);
    wr(SLS_OFS_STOP, SLS_C_NONE, SLS_OKAY);
    $display("done t_hold");
  endtask : t_hold

  task automatic t_out();
    int cs [3] = '{1, 3, 7};
    @(posedge aclk);
    flags[4]  <= 1'b1;
    flags[99] <= 1'b1;
    cy(4);
    chk("term", 32'h6, 32'(tout));
    // relay with inverted fault code while the fault flag is high
    wr(SLS_OFS_OUTSEL + 8'h08, 16'd199, SLS_OKAY);
    cy(4);
    chk("relay", 32'h0, 32'(tout[2]));
    wr(SLS_OFS_OUTSEL + 8'h08, 16'd99, SLS_OKAY);
    cy(4);
    chk("relay", 32'h1, 32'(tout[2]));
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 3; i++)
      begin
        wr(SLS_OFS_OUTSEL, 16'(cs[i] + 100 * p), SLS_OKAY);
        flags[cs[i]] <= 1'b1;
        cy(4);
        chk("term_a", 32'(p == 0), 32'(tout[0]));
        flags[cs[i]] <= 1'b0;
        cy(4);
        chk("term_a", 32'(p == 1), 32'(tout[0]));
      end
    wr(SLS_OFS_OUTSEL, 16'd11, SLS_OKAY);
    cy(4);
    chk("ready", 32'h1, 32'(tout[0]));
    wr(SLS_OFS_OUTSEL, 16'd0, SLS_OKAY);
    freq <= SLS_STARTF_RST;
    pin(5'h01);
    chk("running", 32'h1, 32'(tout[0]));
    freq <= SLS_STARTF_RST - 16'h0001;
    cy(4);
    chk("running", 32'h0, 32'(tout[0]));
    pin(5'h00);
    wr(SLS_OFS_OUTSEL, 16'd146, SLS_OKAY);
    pst <= 1'b1;
    cy(1);
    pst <= 1'b0;
    cy(12);
    chk("ploss", 32'h0, 32'(tout[0]));
    prl <= 1'b1;
    cy(1);
    prl <= 1'b0;
    cy(4);
    chk("ploss", 32'h1, 32'(tout[0]));
    wr(SLS_OFS_OUTSEL, 16'd0, SLS_OKAY);
    $display("done t_out");
  endtask : t_out

  // ==========================================================================
  // main sequence: reset two cycles, then scenarios
  initial
  begin
    cy(2);
    aresetn <= 1'b1;
    t_regs();
    t_refuse();
    t_wire();
    t_coast();
    t_hold();
    t_out();
    print_verdict();
  end
endmodule : sls_start_out_tb_top
